// file: verilog/bcc_top.sv
// Calendar clock with alarm, drift calibration and AXI4-Lite registers
`default_nettype none

module bcc_top #(
	parameter int OSC_DIV       = bcc_pkg::OSC_DIV_CYC, // clk per osc pulse
	parameter int TICKS_PER_SEC = bcc_pkg::OSC_HZ       // osc pulses per s
) (
	input  wire logic                  clk,          // 250 MHz clock
	input  wire logic                  reset,        // sync reset
	input  wire logic                  por,          // power-on reset
	input  wire bcc_pkg::bcc_axi_req_t axi_req,      // AXI4-Lite requests
	output var  bcc_pkg::bcc_axi_rsp_t axi_rsp,      // AXI4-Lite answers
	output logic                       clock_pin_out, // output pin level
	output logic                       clock_pin_oe   // output pin enable
);
	import bcc_pkg::*;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [8:0] bcd_step(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		if (v >= last) begin
			bcd_step = {1'b1, first};
		end else if (v[3:0] >= 4'h9) begin
			bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_step

	function automatic logic [7:0] month_last(input logic [7:0] m,
		input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h02:   month_last = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
			default: month_last = 8'h31;
		endcase
	endfunction : month_last

	function automatic logic alarm_hit(input logic [3:0] mask,
		input bcc_time_t t, input bcc_alarm_t a);
		logic s;
		logic m;
		logic h;
		s = (t.sec == a.sec);
		m = s & (t.min == a.min);
		h = m & (t.hour == a.hour);
		case (mask)
			4'h0, 4'h1: alarm_hit = 1'b1;
			4'h2:    alarm_hit = (t.sec[3:0] == a.sec[3:0]);
			4'h3:    alarm_hit = s;
			4'h4:    alarm_hit = s & (t.min[3:0] == a.min[3:0]);
			4'h5:    alarm_hit = m;
			4'h6:    alarm_hit = h;
			4'h7:    alarm_hit = h & (t.wday == a.wday);
			4'h8:    alarm_hit = h & (t.day == a.day);
			4'h9:    alarm_hit = h & (t.day == a.day) & (t.month == a.month);
			default: alarm_hit = 1'b0; // Reserved codes never fire
		endcase
	endfunction : alarm_hit

	function automatic logic [1:0] ptr_dec(input logic [1:0] p);
		ptr_dec = (p == PTR_FIRST) ? PTR_FIRST : p - 2'b01;
	endfunction : ptr_dec

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = (a == OFS_CFG) || (a == OFS_PAD) || (a == OFS_TIME)
			|| (a == OFS_ALCFG) || (a == OFS_ALARM) || (a == OFS_KEY);
	endfunction : addr_ok

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [15:0]       osc_cnt_reg,  osc_cnt_next;
	logic [16:0]       presc_reg,    presc_next;
	bcc_time_t         time_reg,     time_next;
	logic              en_reg,       en_next;
	logic              unlock_reg,   unlock_next;
	logic              oe_reg,       oe_next;
	logic [1:0]        tptr_reg,     tptr_next;
	logic [7:0]        cal_reg,      cal_next;
	logic              sel_reg,      sel_next;
	logic              al_en_reg,    al_en_next;
	logic              chime_reg,    chime_next;
	logic [3:0]        alarm_interval_select_reg,    alarm_interval_select_next;
	logic [1:0]        aptr_reg,     aptr_next;
	logic [7:0]        alarm_repeat_count_reg,     alarm_repeat_count_next;
	bcc_alarm_t        alarm_reg,    alarm_next;
	logic              pulse_reg,    pulse_next;
	bcc_key_t          key_reg,      key_next;
	logic              aw_held_reg,  aw_held_next;
	logic              w_held_reg,   w_held_next;
	logic [ADDR_W-1:0] awaddr_reg,   awaddr_next;
	logic [31:0]       wdata_reg,    wdata_next;
	logic [3:0]        wstrb_reg,    wstrb_next;
	bcc_axi_rsp_t      rsp_reg,      rsp_next;
	logic              pin_reg,      pin_next;
	logic              pin_oe_reg,   pin_oe_next;

	logic              osc_tick;
	logic              presc_tick;
	logic              sec_tick;
	logic              half_tick;
	logic              half_status;
	logic              ripple;
	logic signed [16:0] cal_adj;
	logic [16:0]       sec_limit;
	logic              alarm_event;
	logic              aw_take;
	logic              w_take;
	logic              ar_take;
	logic              wr_do;
	logic [15:0]       rd_word;

	// ------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------
	// The divider runs whether or not the clock is enabled
	assign osc_tick   = (osc_cnt_reg >= 16'(OSC_DIV - 1));
	assign presc_tick = osc_tick & en_reg;
	assign cal_adj    = {{7{cal_reg[7]}}, cal_reg, 2'b00};
	// Only the first second of each minute is stretched or shortened
	assign sec_limit  = (time_reg.sec == 8'h00)
		? 17'(TICKS_PER_SEC - 1) - cal_adj : 17'(TICKS_PER_SEC - 1);
	assign sec_tick   = presc_tick & (presc_reg >= sec_limit);
	assign half_tick  = presc_tick
		& (presc_reg == 17'(TICKS_PER_SEC / 2 - 1));
	assign half_status = (presc_reg >= 17'(TICKS_PER_SEC / 2));
	// Warn readers while a carry ripple is close
	assign ripple = en_reg
		& (presc_reg + 17'(RIPPLE_TICKS) >= sec_limit);

	// ------------------------------------------------------------
	// Bus handshakes
	// ------------------------------------------------------------
	assign aw_take = axi_req.awvalid & rsp_reg.awready;
	assign w_take  = axi_req.wvalid & rsp_reg.wready;
	assign ar_take = axi_req.arvalid & rsp_reg.arready;
	assign wr_do   = aw_held_reg & w_held_reg;

	always_comb begin
		case (axi_req.araddr)
			OFS_CFG:   rd_word = {en_reg, 1'b0, unlock_reg, ripple,
				half_status, oe_reg, tptr_reg, cal_reg};
			OFS_PAD:   rd_word = {14'h0000, sel_reg, 1'b0};
			OFS_TIME: begin
				case (tptr_reg)
					2'b00:   rd_word = {time_reg.min, time_reg.sec};
					2'b01:   rd_word = {time_reg.wday, time_reg.hour};
					2'b10:   rd_word = {time_reg.month, time_reg.day};
					default: rd_word = {8'h00, time_reg.year};
				endcase
			end
			OFS_ALCFG: rd_word = {al_en_reg, chime_reg, alarm_interval_select_reg, aptr_reg,
				alarm_repeat_count_reg};
			OFS_ALARM: begin
				case (aptr_reg)
					2'b00:   rd_word = {alarm_reg.min, alarm_reg.sec};
					2'b01:   rd_word = {alarm_reg.wday, alarm_reg.hour};
					2'b10:   rd_word = {alarm_reg.month, alarm_reg.day};
					default: rd_word = 16'h0000;
				endcase
			end
			default:   rd_word = 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		osc_cnt_next = osc_tick ? 16'h0000 : osc_cnt_reg + 16'h0001;
		presc_next   = presc_reg;
		time_next    = time_reg;
		en_next      = en_reg;
		unlock_next  = unlock_reg;
		oe_next      = oe_reg;
		tptr_next    = tptr_reg;
		cal_next     = cal_reg;
		sel_next     = sel_reg;
		al_en_next   = al_en_reg;
		chime_next   = chime_reg;
		alarm_interval_select_next   = alarm_interval_select_reg;
		aptr_next    = aptr_reg;
		alarm_repeat_count_next    = alarm_repeat_count_reg;
		alarm_next   = alarm_reg;
		pulse_next   = pulse_reg;
		key_next     = wr_do ? KEY_IDLE : key_reg; // Any write ends the window
		alarm_event  = 1'b0;

		// Calendar advance
		if (presc_tick) begin
			presc_next = sec_tick ? 17'h0_0000 : presc_reg + 17'h0_0001;
		end
		if (sec_tick) begin
			{alarm_event, time_next.sec} = bcd_step(time_reg.sec, 8'h59, 8'h00);
			if (alarm_event) begin
				{alarm_event, time_next.min} =
					bcd_step(time_reg.min, 8'h59, 8'h00);
			end
			if (alarm_event) begin
				{alarm_event, time_next.hour} =
					bcd_step(time_reg.hour, 8'h23, 8'h00);
			end
			if (alarm_event) begin
				time_next.wday = (time_reg.wday >= 8'h06) ? 8'h00
					: time_reg.wday + 8'h01;
				{alarm_event, time_next.day} = bcd_step(time_reg.day,
					month_last(time_reg.month, time_reg.year), 8'h01);
			end
			if (alarm_event) begin
				{alarm_event, time_next.month} =
					bcd_step(time_reg.month, 8'h12, 8'h01);
			end
			if (alarm_event) begin
				{alarm_event, time_next.year} =
					bcd_step(time_reg.year, 8'h99, 8'h00);
			end
		end

		// Alarm
		alarm_event = al_en_reg & ((half_tick & (alarm_interval_select_reg == 4'h0))
			| (sec_tick & alarm_hit(alarm_interval_select_reg, time_next, alarm_reg)));
		if (alarm_event) begin
			if (alarm_repeat_count_reg != 8'h00) begin
				alarm_repeat_count_next = alarm_repeat_count_reg - 8'h01;
			end else if (chime_reg) begin
				alarm_repeat_count_next = RPT_FULL;
			end else begin
				al_en_next = 1'b0;
			end
		end
		// The pulse stays high until the next half-second boundary
		if (alarm_event) begin
			pulse_next = 1'b1;
		end else if (half_tick | sec_tick) begin
			pulse_next = 1'b0;
		end

		// Window reads move their pointer
		if (ar_take && axi_req.araddr == OFS_TIME) begin
			tptr_next = ptr_dec(tptr_next);
		end
		if (ar_take && axi_req.araddr == OFS_ALARM) begin
			aptr_next = ptr_dec(aptr_next);
		end

		// Register writes, after the tick so software wins
		if (wr_do) begin
			case (awaddr_reg)
				OFS_CFG: begin
					if (wstrb_reg[1]) begin
						// Set only in the write right after the key
						unlock_next = wdata_reg[CFG_UNLOCK_BIT]
							& (unlock_reg | (key_reg == KEY_ARMED));
						if (unlock_reg) begin
							en_next = wdata_reg[CFG_EN_BIT];
						end
						oe_next   = wdata_reg[CFG_OE_BIT];
						tptr_next = wdata_reg[9:8];
					end
					if (wstrb_reg[0]) begin
						cal_next = wdata_reg[7:0];
					end
				end
				OFS_PAD: begin
					if (wstrb_reg[0]) begin
						sel_next = wdata_reg[PAD_SEL_BIT];
					end
				end
				OFS_TIME: begin
					if (unlock_reg && wstrb_reg[0]) begin
						case (tptr_reg)
							2'b00: begin
								time_next.sec = wdata_reg[7:0] & MASK_SEC;
								presc_next    = 17'h0_0000;
							end
							2'b01:   time_next.hour = wdata_reg[7:0] & MASK_HOUR;
							2'b10:   time_next.day  = wdata_reg[7:0] & MASK_HOUR;
							default: time_next.year = wdata_reg[7:0];
						endcase
					end
					if (unlock_reg && wstrb_reg[1]) begin
						case (tptr_reg)
							2'b00:   time_next.min = wdata_reg[15:8] & MASK_SEC;
							2'b01:   time_next.wday = wdata_reg[15:8] & MASK_WDAY;
							2'b10:   time_next.month =
								wdata_reg[15:8] & MASK_MONTH;
							default: time_next.year = time_next.year;
						endcase
						tptr_next = ptr_dec(tptr_next);
					end
				end
				OFS_ALCFG: begin
					if (wstrb_reg[1]) begin
						al_en_next = wdata_reg[AL_EN_BIT];
						chime_next = wdata_reg[AL_CHIME_BIT];
						alarm_interval_select_next = wdata_reg[13:10];
						aptr_next  = wdata_reg[9:8];
					end
					if (wstrb_reg[0]) begin
						alarm_repeat_count_next = wdata_reg[7:0];
					end
				end
				OFS_ALARM: begin
					if (wstrb_reg[0]) begin
						case (aptr_reg)
							2'b00:   alarm_next.sec = wdata_reg[7:0] & MASK_SEC;
							2'b01:   alarm_next.hour = wdata_reg[7:0] & MASK_HOUR;
							2'b10:   alarm_next.day = wdata_reg[7:0] & MASK_HOUR;
							default: alarm_next.day = alarm_next.day;
						endcase
					end
					if (wstrb_reg[1]) begin
						case (aptr_reg)
							2'b00:   alarm_next.min = wdata_reg[15:8] & MASK_SEC;
							2'b01:   alarm_next.wday =
								wdata_reg[15:8] & MASK_WDAY;
							2'b10:   alarm_next.month =
								wdata_reg[15:8] & MASK_MONTH;
							default: alarm_next.month = alarm_next.month;
						endcase
						aptr_next = ptr_dec(aptr_next);
					end
				end
				OFS_KEY: begin
					if (wstrb_reg[0] && wdata_reg[7:0] == KEY_FIRST) begin
						key_next = KEY_GOT_FIRST;
					end else if (wstrb_reg[0] && key_reg == KEY_GOT_FIRST
						&& wdata_reg[7:0] == KEY_SECOND) begin
						key_next = KEY_ARMED;
					end
				end
				default: key_next = KEY_IDLE;
			endcase
		end

		// Pin source and enable
		pin_oe_next = oe_next;
		pin_next    = oe_next & (sel_next
			? ~(presc_next >= 17'(TICKS_PER_SEC / 2)) : pulse_next);

		// Bus slave
		aw_held_next = (aw_held_reg | aw_take) & ~wr_do;
		w_held_next  = (w_held_reg | w_take) & ~wr_do;
		awaddr_next  = aw_take ? axi_req.awaddr : awaddr_reg;
		wdata_next   = w_take ? axi_req.wdata : wdata_reg;
		wstrb_next   = w_take ? axi_req.wstrb : wstrb_reg;
		rsp_next     = rsp_reg;
		if (wr_do) begin
			rsp_next.bvalid = 1'b1;
			rsp_next.bresp  = addr_ok(awaddr_reg) ? RESP_OKAY : RESP_ERR;
		end else if (rsp_reg.bvalid && axi_req.bready) begin
			rsp_next.bvalid = 1'b0;
		end
		if (ar_take) begin
			rsp_next.rvalid = 1'b1;
			rsp_next.rdata  = {16'h0000, rd_word};
			rsp_next.rresp  = addr_ok(axi_req.araddr) ? RESP_OKAY : RESP_ERR;
		end else if (rsp_reg.rvalid && axi_req.rready) begin
			rsp_next.rvalid = 1'b0;
		end
		rsp_next.awready = ~aw_held_next & ~rsp_next.bvalid;
		rsp_next.wready  = ~w_held_next & ~rsp_next.bvalid;
		rsp_next.arready = ~rsp_next.rvalid;
	end

	// ------------------------------------------------------------
	// Registers kept through ordinary reset
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (por) begin
			osc_cnt_reg <= 16'h0000;
			presc_reg   <= 17'h0_0000;
			time_reg    <= TIME_RESET;
			{en_reg, unlock_reg, oe_reg, tptr_reg, cal_reg} <=
				{CFG_RESET[15], CFG_RESET[13], CFG_RESET[10],
				CFG_RESET[9:8], CFG_RESET[7:0]};
			sel_reg     <= 1'b0;
		end else begin
			osc_cnt_reg <= osc_cnt_next;
			presc_reg   <= presc_next;
			time_reg    <= time_next;
			en_reg      <= en_next;
			unlock_reg  <= unlock_next;
			oe_reg      <= oe_next;
			tptr_reg    <= tptr_next;
			cal_reg     <= cal_next;
			sel_reg     <= sel_next;
		end
	end

	// ------------------------------------------------------------
	// Registers cleared by any reset
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (por || reset) begin
			al_en_reg   <= 1'b0;
			chime_reg   <= 1'b0;
			alarm_interval_select_reg   <= 4'h0;
			aptr_reg    <= 2'b00;
			alarm_repeat_count_reg    <= 8'h00;
			alarm_reg   <= ALARM_RESET;
			pulse_reg   <= 1'b0;
			key_reg     <= KEY_IDLE;
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			rsp_reg     <= '{1'b1, 1'b1, 1'b0, RESP_OKAY, 1'b1, 1'b0,
				32'h0000_0000, RESP_OKAY};
			pin_reg     <= 1'b0;
			pin_oe_reg  <= 1'b0;
		end else begin
			al_en_reg   <= al_en_next;
			chime_reg   <= chime_next;
			alarm_interval_select_reg   <= alarm_interval_select_next;
			aptr_reg    <= aptr_next;
			alarm_repeat_count_reg    <= alarm_repeat_count_next;
			alarm_reg   <= alarm_next;
			pulse_reg   <= pulse_next;
			key_reg     <= key_next;
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			rsp_reg     <= rsp_next;
			pin_reg     <= pin_next;
			pin_oe_reg  <= pin_oe_next;
		end
	end

	assign axi_rsp       = rsp_reg;
	assign clock_pin_out = pin_reg;
	assign clock_pin_oe  = pin_oe_reg;

endmodule : bcc_top

`default_nettype wire

// file: verilog/bcc_pkg.sv
// Package: constants, register map and carrier types of the calendar clock
`default_nettype none

package bcc_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int         ADDR_W    = 8;
	localparam logic [7:0] OFS_CFG   = 8'h00;
	localparam logic [7:0] OFS_PAD   = 8'h04;
	localparam logic [7:0] OFS_TIME  = 8'h08;
	localparam logic [7:0] OFS_ALCFG = 8'h0C;
	localparam logic [7:0] OFS_ALARM = 8'h10;
	localparam logic [7:0] OFS_KEY   = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CFG_EN_BIT     = 15;
	localparam int CFG_UNLOCK_BIT = 13;
	localparam int CFG_OE_BIT     = 10;
	localparam int PAD_SEL_BIT    = 1;
	localparam int AL_EN_BIT      = 15;
	localparam int AL_CHIME_BIT   = 14;

	// ------------------------------------------------------------
	// Values
	// ------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [7:0] RPT_FULL   = 8'hFF;
	localparam logic [1:0] PTR_FIRST  = 2'b00;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_ERR   = 2'b10;
	localparam logic [7:0] MASK_SEC   = 8'h7F;
	localparam logic [7:0] MASK_HOUR  = 8'h3F;
	localparam logic [7:0] MASK_WDAY  = 8'h07;
	localparam logic [7:0] MASK_MONTH = 8'h1F;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 250_000_000;
	localparam int OSC_HZ       = 32_768;
	localparam int OSC_DIV_CYC  = CLK_HZ / OSC_HZ;
	localparam int RIPPLE_TICKS = 32;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} bcc_time_t;

	typedef struct packed {
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} bcc_alarm_t;

	localparam bcc_time_t  TIME_RESET  = '{8'h00, 8'h01, 8'h01, 8'h00,
		8'h00, 8'h00, 8'h00};
	localparam bcc_alarm_t ALARM_RESET = '{8'h01, 8'h01, 8'h00, 8'h00,
		8'h00, 8'h00};
	localparam logic [15:0] CFG_RESET  = 16'h0000;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} bcc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} bcc_axi_rsp_t;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_ARMED
	} bcc_key_t;

endpackage : bcc_pkg

`default_nettype wire

// file: dv/bcc_top_sva.sv
// Checker: bus answer and pin properties of the calendar clock
`default_nettype none

module bcc_top_sva
	import bcc_pkg::*;
(
	input wire logic         clk,           // clock
	input wire logic         reset,         // sync reset
	input wire logic         por,           // power-on reset
	input wire bcc_axi_req_t axi_req,       // bus requests
	input wire bcc_axi_rsp_t axi_rsp,       // bus answers
	input wire logic         clock_pin_out, // pin level
	input wire logic         clock_pin_oe   // pin enable
);
	logic aw_go;
	logic ar_go;
	logic bad_ar;
	logic bad_aw;

	// Bench offers address and data together, so both land on one edge
	assign aw_go = axi_req.awvalid && axi_rsp.awready
		&& axi_req.wvalid && axi_rsp.wready;
	assign ar_go = axi_req.arvalid && axi_rsp.arready;
	assign bad_ar = axi_req.araddr > OFS_KEY || axi_req.araddr[1:0] != 2'b00;
	assign bad_aw = axi_req.awaddr > OFS_KEY || axi_req.awaddr[1:0] != 2'b00;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || por);

	property p_pin_quiet; !clock_pin_oe |-> !clock_pin_out; endproperty
	a_pin_quiet: assert property (p_pin_quiet)
		else $error("pin high while disabled");
	property p_wr_answer;
		aw_go |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer late or early");
	property p_wr_busy; aw_go |=> !axi_rsp.awready[*2]; endproperty
	a_wr_busy: assert property (p_wr_busy)
		else $error("write address accepted too soon");
	property p_wr_refuse;
		aw_go && bad_aw |-> ##2 axi_rsp.bresp == RESP_ERR;
	endproperty
	a_wr_refuse: assert property (p_wr_refuse)
		else $error("unmapped write not refused");
	property p_rd_answer; ar_go |=> axi_rsp.rvalid && !axi_rsp.arready; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer missing");
	property p_rd_refuse;
		ar_go && bad_ar |=> axi_rsp.rresp == RESP_ERR
			&& axi_rsp.rdata == 32'h0000_0000;
	endproperty
	a_rd_refuse: assert property (p_rd_refuse)
		else $error("unmapped read not refused");
	property p_rd_half;
		ar_go && !bad_ar |=> axi_rsp.rresp == RESP_OKAY
			&& axi_rsp.rdata[31:16] == 16'h0000;
	endproperty
	a_rd_half: assert property (p_rd_half)
		else $error("mapped read bad response or upper half");
	property p_key_blank;
		ar_go && axi_req.araddr == OFS_KEY
			|=> axi_rsp.rdata == 32'h0000_0000;
	endproperty
	a_key_blank: assert property (p_key_blank)
		else $error("key register read not zero");
endmodule : bcc_top_sva

bind bcc_top bcc_top_sva u_sva (
	.clk(clk), .reset(reset), .por(por), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .clock_pin_out(clock_pin_out),
	.clock_pin_oe(clock_pin_oe));

`default_nettype wire

// file: dv/bcc_top_test.sv
// Testbench: register-level scenarios for the calendar clock
`default_nettype none

module bcc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import bcc_pkg::*;

	// Short second keeps the run small; half second is 32 cycles
	localparam int TPS = 64;
	logic         clk;
	logic         reset;
	logic         por;
	bcc_axi_req_t req;
	bcc_axi_rsp_t rsp;
	logic         pin;
	logic         pin_oe;
	logic         last;
	logic [31:0]  rd_val;
	logic [1:0]   resp;
	logic [15:0]  tab [4];
	int           error_cnt;
	int           checks_done;
	int           n;

	bcc_top #(.OSC_DIV(1), .TICKS_PER_SEC(TPS)) u_dut (
		.clk(clk), .reset(reset), .por(por), .axi_req(req), .axi_rsp(rsp),
		.clock_pin_out(pin), .clock_pin_oe(pin_oe));

	always #2 clk = ~clk;

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s = 4'h3);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= {16'h0000, d};
		req.wstrb   <= s;
		do begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		resp = rsp.bresp;
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		do begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		rd_val = rsp.rdata;
		resp   = rsp.rresp;
		chk(rd_val, exp);
	endtask : rdc

	task automatic wait_pin(input logic lvl);
		do @(posedge clk); while (pin !== lvl);
	endtask : wait_pin

	task automatic summarize();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	initial begin
		#60us;
		error_cnt++;
		summarize();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		por = 1'b1;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		error_cnt = 0;
		checks_done = 0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		por   <= 1'b0;
		@(posedge clk);
		rdc(OFS_CFG, 32'h0000_0000);
		wr(OFS_CFG, 16'h8000);
		wr(OFS_TIME, 16'h1234);
		rdc(OFS_CFG, 32'h0000_0000);
		rdc(OFS_TIME, 32'h0000_0000);
		// A write between the two keys must cancel the unlock
		wr(OFS_KEY, {8'h00, KEY_FIRST});
		wr(OFS_PAD, 16'h0000);
		wr(OFS_KEY, {8'h00, KEY_SECOND});
		wr(OFS_CFG, 16'h2000);
		rdc(OFS_CFG, 32'h0000_0000);
		rdc(OFS_KEY, 32'h0000_0000);
		wr(OFS_KEY, {8'h00, KEY_FIRST});
		wr(OFS_KEY, {8'h00, KEY_SECOND});
		wr(OFS_CFG, 16'h2300);
		tab = '{16'h0099, 16'h1231, 16'h0323, 16'h5958};
		foreach (tab[i]) wr(OFS_TIME, tab[i]);
		rdc(OFS_CFG, 32'h0000_2000);
		wr(OFS_CFG, 16'h2300);
		foreach (tab[i]) rdc(OFS_TIME, {16'h0000, tab[i]});
		rdc(OFS_TIME, 32'h0000_5958);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rdc(OFS_CFG, 32'h0000_2000);
		// Two seconds from 23:59:58 on the last day of the century
		wr(OFS_CFG, 16'hA000);
		repeat (160) @(posedge clk);
		wr(OFS_CFG, 16'h2300);
		tab = '{16'h0000, 16'h0101, 16'h0400, 16'h0000};
		foreach (tab[i]) rdc(OFS_TIME, {16'h0000, tab[i]});
		wr(OFS_ALCFG, 16'h0200);
		tab = '{16'h0000, 16'h0102, 16'h0304, 16'h0506};
		for (int k = 1; k < 4; k++) wr(OFS_ALARM, tab[k]);
		rdc(OFS_ALCFG, 32'h0000_0000);
		wr(OFS_ALCFG, 16'h0300);
		foreach (tab[i]) rdc(OFS_ALARM, {16'h0000, tab[i]});
		wr(OFS_PAD, 16'h0002);
		wr(OFS_CFG, 16'hA400);
		wait_pin(1'b0);
		wait_pin(1'b1);
		rdc(OFS_CFG, 32'h0000_A400);
		chk(32'(pin_oe), 32'h0000_0001);
		wait_pin(1'b0);
		// A short second puts its whole second half in the ripple window
		rdc(OFS_CFG, 32'h0000_BC00);
		wr(OFS_TIME, 16'h0000, 4'h1);
		rdc(OFS_CFG, 32'h0000_A400);
		// Every second, one repeat: two pulses, then enable drops
		wr(OFS_PAD, 16'h0000);
		wr(OFS_ALCFG, 16'h8401);
		n = 0;
		last = pin;
		repeat (250) begin
			@(posedge clk);
			if (pin === 1'b1 && last === 1'b0) n++;
			last = pin;
		end
		chk(32'(n), 32'h0000_0002);
		rdc(OFS_ALCFG, 32'h0000_0400);
		wr(OFS_ALCFG, 16'hC400);
		wait_pin(1'b1);
		rdc(OFS_ALCFG, 32'h0000_C4FF);
		// Half-second mask: two boundaries use up one repeat
		wr(OFS_ALCFG, 16'h8001);
		repeat (66) @(posedge clk);
		rdc(OFS_ALCFG, 32'h0000_0000);
		rdc(8'h18, 32'h0000_0000);
		chk(32'(resp), 32'(RESP_ERR));
		wr(8'h1C, 16'hFFFF);
		chk(32'(resp), 32'(RESP_ERR));
		// Calibration 0x01 shortens second 00 to 60 ticks
		wr(OFS_CFG, 16'hA401);
		wr(OFS_TIME, 16'h0000);
		repeat (57) @(posedge clk);
		rdc(OFS_TIME, 32'h0000_0000);
		rdc(OFS_TIME, 32'h0000_0001);
		wr(OFS_CFG, 16'h2000);
		repeat (2) @(posedge clk);
		chk(32'(pin_oe), 32'h0000_0000);
		summarize();
	end
endmodule : bcc_top_test

`default_nettype wire
